// ---- design/wdtc_pkg.sv ----
// constants shared by the watchdog timer control block
`default_nettype none
package wdtc_pkg;
	// ----------------------------------------------------------------
	// register indexes on the plain register port
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_STATUS_ADDR  = 2'h0;
	localparam logic [1:0] RESET_SOURCE_ADDR = 2'h1;

	// ----------------------------------------------------------------
	// control and status field positions, then the reset source flag bit
	// ----------------------------------------------------------------
	localparam int IRQ_FLAG_BIT    = 7;
	localparam int IRQ_ENABLE_BIT  = 6;
	localparam int PRESCALE_HI_BIT = 5;
	localparam int CHANGE_EN_BIT   = 4;
	localparam int RESET_EN_BIT    = 3;
	localparam int PRESCALE_LO_MSB = 2;
	localparam int WDOG_SRC_BIT    = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] PRESCALE_RESET = 4'h0;
	localparam logic       FLAG_RESET     = 1'b0;
	localparam logic       ENABLE_RESET   = 1'b0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         SYS_CLK_HZ       = 10000000;
	localparam int         WDT_OSC_HZ       = 128000;
	localparam logic [2:0] CE_WINDOW_CYCLES = 3'h4;
	localparam logic [3:0] PRESCALE_MAX     = 4'h9;
	localparam int         BASE_TIMEOUT     = 2048;
endpackage : wdtc_pkg
`default_nettype wire

// ---- design/wdtc_top.sv ----
// watchdog timer with timed-change protected control and status register
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module wdtc_top #(
	parameter int CNT_W        = 21,
	parameter int BASE_TIMEOUT = wdtc_pkg::BASE_TIMEOUT
) (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	// register port
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// cpu side
	input  wire logic       i_global_irq_enable,
	input  wire logic       i_vector_ack,
	input  wire logic       i_restart,
	output logic            o_irq,
	output logic            o_sys_reset,
	// pins
	input  wire logic       i_wdt_osc,
	input  wire logic       i_always_on_fuse
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// reserved prescaler codes fall back to the longest period
	function automatic logic [CNT_W-1:0] timeout_limit(input logic [3:0] code);
		logic [3:0] c;
		c = (code > wdtc_pkg::PRESCALE_MAX) ? wdtc_pkg::PRESCALE_MAX : code;
		timeout_limit = CNT_W'(BASE_TIMEOUT) << c;
	endfunction : timeout_limit

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// synchroniser stages, counter and register fields
	logic [2:0]       osc_sync_q;
	logic [1:0]       fuse_sync_q;
	logic [CNT_W-1:0] cnt_q;
	logic [3:0]       prescale_q;
	logic             flag_q;
	logic             ie_q;
	logic             wde_q;
	logic             ce_q;
	logic [2:0]       ce_cnt_q;
	logic             watchdog_reset_source_flag_q;
	// decoded mode and strobes, all combinational
	logic             osc_tick;
	logic             fuse_prog;
	logic             wde_eff;
	logic             ie_eff;
	logic             running;
	logic             timeout;
	logic             do_irq;
	logic             do_reset;
	logic             wr_ctrl;
	logic             wr_src;
	logic             open_seq;
	logic             prot_ok;
	logic [7:0]       ctrl_view;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// oscillator gets a third stage so the edge detector never sees stage one
	// fuse stages reset to unprogrammed so a cold start never locks the enables
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			osc_sync_q  <= 3'h0;
			fuse_sync_q <= 2'h3;
		end else begin
			osc_sync_q  <= {osc_sync_q[1:0], i_wdt_osc};
			fuse_sync_q <= {fuse_sync_q[0], i_always_on_fuse};
		end
	end

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign osc_tick  = osc_sync_q[1] & ~osc_sync_q[2];
	assign fuse_prog = ~fuse_sync_q[1];
	assign wde_eff   = wde_q | watchdog_reset_source_flag_q | fuse_prog;
	assign ie_eff    = ie_q & ~fuse_prog;
	assign running   = wde_eff | ie_eff;
	assign timeout   = running & osc_tick & (cnt_q == timeout_limit(prescale_q) - CNT_W'(1));
	// flag already pending in combined mode turns the next timeout into a reset
	assign do_irq    = timeout & ie_eff & ~(wde_eff & flag_q);
	assign do_reset  = timeout & wde_eff & ~do_irq;
	// register port decode; indexes 2 and 3 fall through and are ignored
	assign wr_ctrl   = i_wr & (i_addr == wdtc_pkg::CTRL_STATUS_ADDR);
	assign wr_src    = i_wr & (i_addr == wdtc_pkg::RESET_SOURCE_ADDR);
	assign open_seq  = wr_ctrl & i_wdata[wdtc_pkg::CHANGE_EN_BIT] & i_wdata[wdtc_pkg::RESET_EN_BIT];
	assign prot_ok   = wr_ctrl & ce_q & ~i_wdata[wdtc_pkg::CHANGE_EN_BIT];
	assign ctrl_view = {flag_q, ie_eff, prescale_q[3], ce_q, wde_eff, prescale_q[2:0]};

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	// a prescaler drop below the current count waits for a wrap; restart first
	// holding the count at zero while stopped makes a later enable start a full period
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (i_restart || !running || timeout || o_sys_reset) begin
			cnt_q <= '0;
		end else if (osc_tick) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// interrupt flag and enable
	// ----------------------------------------------------------------
	// a timeout in the clearing cycle still leaves the flag set
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_q <= wdtc_pkg::FLAG_RESET;
		end else if (o_sys_reset) begin
			flag_q <= wdtc_pkg::FLAG_RESET;
		end else if (do_irq) begin
			flag_q <= 1'b1;
		end else if (i_vector_ack || (wr_ctrl && i_wdata[wdtc_pkg::IRQ_FLAG_BIT])) begin
			flag_q <= 1'b0;
		end
	end

	// a software write of the enable beats the vector clear in the same cycle
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ie_q <= wdtc_pkg::ENABLE_RESET;
		end else if (o_sys_reset) begin
			ie_q <= wdtc_pkg::ENABLE_RESET;
		end else if (wr_ctrl) begin
			ie_q <= i_wdata[wdtc_pkg::IRQ_ENABLE_BIT];
		end else if (i_vector_ack && wde_eff) begin
			ie_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// protected reset enable and prescaler
	// ----------------------------------------------------------------
	// setting the enable is always allowed, only clearing is guarded
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wde_q      <= wdtc_pkg::ENABLE_RESET;
			prescale_q <= wdtc_pkg::PRESCALE_RESET;
		end else if (o_sys_reset) begin
			wde_q      <= 1'b1;
			prescale_q <= wdtc_pkg::PRESCALE_RESET;
		end else if (prot_ok) begin
			wde_q      <= i_wdata[wdtc_pkg::RESET_EN_BIT];
			prescale_q <= {i_wdata[wdtc_pkg::PRESCALE_HI_BIT], i_wdata[wdtc_pkg::PRESCALE_LO_MSB:0]};
		end else if (wr_ctrl && i_wdata[wdtc_pkg::RESET_EN_BIT]) begin
			wde_q      <= 1'b1;
		end
	end

	// change window: open for four cycles, shut early by a write with it clear
	// the count runs down from three so the fourth cycle after the write is the last one open
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ce_q     <= 1'b0;
			ce_cnt_q <= 3'h0;
		end else if (o_sys_reset) begin
			ce_q     <= 1'b0;
			ce_cnt_q <= 3'h0;
		end else if (open_seq) begin
			ce_q     <= 1'b1;
			ce_cnt_q <= wdtc_pkg::CE_WINDOW_CYCLES - 3'h1;
		end else if (wr_ctrl || (ce_q && ce_cnt_q == 3'h0)) begin
			ce_q     <= 1'b0;
			ce_cnt_q <= 3'h0;
		end else if (ce_q) begin
			ce_cnt_q <= ce_cnt_q - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// reset source flag
	// ----------------------------------------------------------------
	// only power-on clears it by itself; a new watchdog reset beats a software clear
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			watchdog_reset_source_flag_q <= 1'b0;
		end else if (o_sys_reset) begin
			watchdog_reset_source_flag_q <= 1'b1;
		end else if (wr_src && !i_wdata[wdtc_pkg::WDOG_SRC_BIT]) begin
			watchdog_reset_source_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// request is a registered level; the ack cycle masks it so one service is not taken twice
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq       <= 1'b0;
			o_sys_reset <= 1'b0;
		end else begin
			o_irq       <= flag_q & ie_eff & i_global_irq_enable & ~i_vector_ack;
			o_sys_reset <= do_reset;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd && i_addr == wdtc_pkg::CTRL_STATUS_ADDR) begin
			o_rdata <= ctrl_view;
		end else if (i_rd && i_addr == wdtc_pkg::RESET_SOURCE_ADDR) begin
			o_rdata <= {4'h0, watchdog_reset_source_flag_q, 3'h0};
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_flag_on_timeout: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		do_irq |=> flag_q) else $error("timeout did not set flag");
	a_flag_vector_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_vector_ack && !do_irq |=> !flag_q) else $error("vector did not clear flag");
	a_irq_gating: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_irq |-> $past(flag_q) && $past(i_global_irq_enable)) else $error("irq without enables");
	a_fuse_forces_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		timeout && fuse_prog |=> o_sys_reset && $stable(flag_q)) else $error("fuse mode no reset");
	a_combined_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_vector_ack && wde_eff && !wr_ctrl |=> !ie_q) else $error("enable not cleared");
	a_second_timeout: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		timeout && ie_eff && wde_eff && flag_q |=> o_sys_reset) else $error("pending flag no reset");
	a_protected_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl && !ce_q && wde_q && !o_sys_reset |=> wde_q && $stable(prescale_q)) else $error("unprotected change");
	a_change_window: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(ce_q) ##0 (!i_wr)[*4] |=> !ce_q) else $error("change window length");
	a_source_forces: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_rd && i_addr == wdtc_pkg::CTRL_STATUS_ADDR && watchdog_reset_source_flag_q |=> o_rdata[3]) else $error("enable not forced");
	a_reset_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_sys_reset |=> !o_sys_reset ##0 wde_q && watchdog_reset_source_flag_q) else $error("reset pulse not single");
	a_restart_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_restart |=> cnt_q == '0) else $error("restart ignored");

	// ----------------------------------------------------------------
	// mode, lock and field checks
	// ----------------------------------------------------------------
	a_fuse_locks: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_rd && i_addr == wdtc_pkg::CTRL_STATUS_ADDR && fuse_prog |=> o_rdata[3] && !o_rdata[6]) else $error("fuse lock");
	a_reset_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		timeout && wde_eff && !ie_eff |=> o_sys_reset) else $error("reset mode no reset");
	a_irq_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		timeout && ie_eff && !wde_eff && !o_sys_reset |=> flag_q && !o_sys_reset) else $error("interrupt mode wrong");
	a_stopped_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!running |=> cnt_q == '0 && !o_sys_reset) else $error("stopped watchdog active");
	a_set_enable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl && i_wdata[wdtc_pkg::RESET_EN_BIT] |=> wde_q) else $error("enable set refused");
	a_flag_write_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl && i_wdata[wdtc_pkg::IRQ_FLAG_BIT] && !do_irq |=> !flag_q) else $error("flag write one ignored");
	a_window_open: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		open_seq && !o_sys_reset |=> ce_q) else $error("window did not open");
	a_prescale_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		prot_ok && !o_sys_reset |=> prescale_q == {$past(i_wdata[wdtc_pkg::PRESCALE_HI_BIT]),
		$past(i_wdata[wdtc_pkg::PRESCALE_LO_MSB:0])}) else $error("prescale field split");
	a_timeout_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		timeout |=> cnt_q == '0) else $error("timeout did not restart count");
	a_reset_clears_irq: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_sys_reset |=> !flag_q && !ie_q && prescale_q == wdtc_pkg::PRESCALE_RESET) else $error("reset state wrong");
	a_vector_masks_irq: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_vector_ack |=> !o_irq) else $error("request after vector");
	a_irq_request: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		flag_q && ie_eff && i_global_irq_enable && !i_vector_ack |=> o_irq) else $error("request missing");
endmodule : wdtc_top

`default_nettype wire

// ---- verif/wdtc_test.sv ----
// self-checking bench for the watchdog timer control block
`timescale 1ns/1ps
`default_nettype none
module wdtc_test;
	// ----------------------------------------------------------------
	// signals, table and design
	// ----------------------------------------------------------------
	localparam int LIMIT = 20000; // whole sequence needs about a thousand cycles
	// address, write data, value read back from that address
	localparam logic [17:0] ROWS [7] = '{{2'h0, 8'h40, 8'h40}, {2'h0, 8'h27, 8'h00}, {2'h0, 8'h08, 8'h08},
		{2'h0, 8'h00, 8'h08}, {2'h0, 8'h10, 8'h08}, {2'h2, 8'hFF, 8'h00}, {2'h1, 8'hFF, 8'h00}};
	localparam logic [3:0] CODES [3] = '{4'h0, 4'h1, 4'h3};
	logic       i_sys_clk           = 1'b0;
	logic       i_rst               = 1'b1;
	logic [1:0] i_addr              = 2'h0;
	logic [7:0] i_wdata             = 8'h00;
	logic       i_wr                = 1'b0;
	logic       i_rd                = 1'b0;
	logic       i_global_irq_enable = 1'b1;
	logic       i_vector_ack        = 1'b0;
	logic       i_restart           = 1'b0;
	logic       i_wdt_osc           = 1'b0;
	logic       i_always_on_fuse    = 1'b1;
	logic       osc_on              = 1'b0;
	logic [1:0] osc_ph              = 2'h0;
	logic [7:0] o_rdata;
	logic       o_irq;
	logic       o_sys_reset;
	int         n_errors            = 0;
	int         compares            = 0;
	int         cycles              = 0;
	int         n;
	int         hits;
	int         exp_n;

	always #50 i_sys_clk = ~i_sys_clk;

	// slow oscillator: three clocks high, three low, so one tick per six clocks
	always @(posedge i_sys_clk) begin
		if (osc_on) begin
			osc_ph <= (osc_ph == 2'h2) ? 2'h0 : osc_ph + 2'h1;
			if (osc_ph == 2'h2) begin
				i_wdt_osc <= ~i_wdt_osc;
			end
		end
	end

	// hang guard
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			wrap_up();
		end
	end

	wdtc_top #(.CNT_W(21), .BASE_TIMEOUT(4)) wdtc_top_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
		.i_vector_ack(i_vector_ack), .i_restart(i_restart), .o_irq(o_irq), .o_sys_reset(o_sys_reset),
		.i_wdt_osc(i_wdt_osc), .i_always_on_fuse(i_always_on_fuse));

	// ----------------------------------------------------------------
	// bus tasks and checks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe, so look mid-cycle
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string msg);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		chk(o_rdata, exp, msg);
	endtask : rd_chk

	// timed sequence: open the window, then the new value with change enable low
	task automatic prot(input logic [7:0] d);
		wr_reg(2'h0, 8'h18);
		wr_reg(2'h0, d);
	endtask : prot

	task automatic pulse(input logic ack);
		@(posedge i_sys_clk);
		if (ack) i_vector_ack <= 1'b1;
		else i_restart <= 1'b1;
		@(posedge i_sys_clk);
		i_vector_ack <= 1'b0;
		i_restart    <= 1'b0;
	endtask : pulse

	// bounded wait for reset pulse or interrupt; n holds the cycles spent
	task automatic wait_evt(input logic rst_evt, input int lim);
		n = 0;
		while (n < lim && ((rst_evt ? o_sys_reset : o_irq) !== 1'b1)) begin
			@(negedge i_sys_clk);
			n++;
		end
	endtask : wait_evt

	task wrap_up;
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd_chk(2'h0, 8'h00, "ctrl after reset");
		rd_chk(2'h1, 8'h00, "source after reset");
		foreach (ROWS[i]) begin
			wr_reg(ROWS[i][17:16], ROWS[i][15:8]);
			rd_chk(ROWS[i][17:16], ROWS[i][7:0], "table row");
		end
		prot(8'h21);
		rd_chk(2'h0, 8'h21, "protected change");
		wr_reg(2'h0, 8'h18);
		repeat (2) @(posedge i_sys_clk);
		wr_reg(2'h0, 8'h00);
		rd_chk(2'h0, 8'h00, "last window cycle");
		wr_reg(2'h0, 8'h08);
		wr_reg(2'h0, 8'h18);
		repeat (3) @(posedge i_sys_clk);
		wr_reg(2'h0, 8'h00);
		rd_chk(2'h0, 8'h08, "window closed");
		osc_on <= 1'b1;
		// reset mode period per prescale code, slack for restart phase and sync
		foreach (CODES[k]) begin
			exp_n = 6 * (4 << CODES[k]);
			pulse(1'b0);
			prot({2'b00, CODES[k][3], 2'b01, CODES[k][2:0]});
			pulse(1'b0);
			wait_evt(1'b1, 400);
			chk({7'h0, n >= exp_n - 8 && n <= exp_n + 8}, 8'h01, "timeout period");
			@(negedge i_sys_clk);
			chk({7'h0, o_sys_reset}, 8'h00, "reset pulse width");
		end
		rd_chk(2'h1, 8'h08, "source flag after timeout");
		rd_chk(2'h0, 8'h08, "reset mode kept");
		pulse(1'b0);
		prot(8'h00);
		rd_chk(2'h0, 8'h08, "enable held by source flag");
		wr_reg(2'h1, 8'h00);
		prot(8'h00);
		rd_chk(2'h0, 8'h00, "enable cleared after flag");
		wait_evt(1'b1, 300);
		chk({7'h0, n == 300 && o_irq === 1'b0}, 8'h01, "stopped mode");
		wr_reg(2'h0, 8'h40);
		pulse(1'b0);
		wait_evt(1'b0, 60);
		chk({7'h0, n < 60 && o_sys_reset === 1'b0}, 8'h01, "interrupt mode");
		rd_chk(2'h0, 8'hC0, "flag set");
		wr_reg(2'h0, 8'hC0);
		rd_chk(2'h0, 8'h40, "flag write one");
		@(posedge i_sys_clk);
		i_global_irq_enable <= 1'b0;
		repeat (40) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk({7'h0, o_irq}, 8'h00, "global enable off");
		rd_chk(2'h0, 8'hC0, "flag without request");
		pulse(1'b0);
		pulse(1'b1);
		rd_chk(2'h0, 8'h40, "vector clears flag");
		@(posedge i_sys_clk);
		i_global_irq_enable <= 1'b1;
		wr_reg(2'h0, 8'h48);
		pulse(1'b0);
		wait_evt(1'b0, 60);
		chk({7'h0, n < 60 && o_sys_reset === 1'b0}, 8'h01, "combined first timeout");
		pulse(1'b1);
		rd_chk(2'h0, 8'h08, "vector leaves reset mode");
		wr_reg(2'h0, 8'h48);
		wait_evt(1'b0, 60);
		chk({7'h0, n < 60}, 8'h01, "interrupt enable re-set");
		wait_evt(1'b1, 60);
		chk({7'h0, n < 60}, 8'h01, "unserviced timeout resets");
		hits = 0;
		repeat (8) begin
			pulse(1'b0);
			wait_evt(1'b1, 10);
			if (n < 10) hits++;
		end
		chk({7'h0, hits == 0}, 8'h01, "restart holds off timeout");
		@(posedge i_sys_clk);
		i_always_on_fuse <= 1'b0;
		wr_reg(2'h1, 8'h00);
		pulse(1'b0);
		prot(8'h40);
		rd_chk(2'h0, 8'h08, "fuse locks enables");
		wait_evt(1'b1, 60);
		chk({7'h0, n < 60 && o_irq === 1'b0}, 8'h01, "fuse forces reset mode");
		@(posedge i_sys_clk);
		i_always_on_fuse <= 1'b1;
		i_rst            <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd_chk(2'h0, 8'h00, "ctrl after second reset");
		rd_chk(2'h1, 8'h00, "source after second reset");
		wrap_up();
	end
endmodule : wdtc_test
`default_nettype wire
